// *** rtl/eirq_regs.vh ***
// register offsets, field positions and reset values of the external request status block
`ifndef EIRQ_REGS_VH
`define EIRQ_REGS_VH

// ===========================================================================
// byte offsets on the bus
`define EIRQ_ADR_STATUS 8'h00
`define EIRQ_ADR_SENSE 8'h04
`define EIRQ_ADR_EVT 8'h08
`define EIRQ_ADR_MASK 8'h0C
`define EIRQ_ADR_ARMED 8'h10

// ===========================================================================
// field layout of the status register
`define EIRQ_FLAG_LSB 0
`define EIRQ_FLAG_MSB 7
`define EIRQ_LEVEL_LSB 8
`define EIRQ_LEVEL_MSB 15

// ===========================================================================
// sense codes
`define EIRQ_SENSE_LOW 2'b00
`define EIRQ_SENSE_FALL 2'b01
`define EIRQ_SENSE_RISE 2'b10
`define EIRQ_SENSE_BOTH 2'b11

// ===========================================================================
// reset values
`define EIRQ_RST_FLAGS 8'h00
`define EIRQ_RST_SENSE 16'h0000
`define EIRQ_RST_EVT 8'h00
`define EIRQ_RST_MASK 8'h00
`define EIRQ_RST_DATA 32'h0000_0000

// ===========================================================================
// timing: the bus answer comes this many cycles after a request is seen
`define EIRQ_ACK_CYCLES 1

`endif

// *** rtl/eirq_flag_cell.v ***
// request flag of one external request pin: level follow, edge latch and clearing
`timescale 1ns/1ps
`default_nettype none
`include "eirq_regs.vh"

module eirq_flag_cell (
    input wire clk,
    input wire rst_n,
    input wire [1:0] sense,
    input wire pin,
    input wire rd_seen,
    input wire wr_zero,
    input wire accept,
    output wire flag,
    output wire armed,
    output wire flag_rise
);

// ===========================================================================
// edge decode
function edge_hit;
    input [1:0] mode;
    input prev;
    input now;
    begin
        case (mode)
            `EIRQ_SENSE_FALL: edge_hit = prev & ~now;
            `EIRQ_SENSE_RISE: edge_hit = ~prev & now;
            `EIRQ_SENSE_BOTH: edge_hit = prev ^ now;
            default: edge_hit = 1'b0;
        endcase
    end
endfunction

reg flag_ff;
reg armed_ff;
reg prev_ff;
reg prev_valid_ff;
reg nxt_flag;
reg nxt_armed;
wire edge_mode;
wire hit;

assign edge_mode = |sense; // [R10]
assign hit = prev_valid_ff & edge_hit(sense, prev_ff, pin); // [R7]

// ===========================================================================
// previous pin sample; no edge is seen before the first sample after reset
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        prev_ff <= 1'b0;
        prev_valid_ff <= 1'b0;
    end else begin
        prev_ff <= pin;
        prev_valid_ff <= 1'b1;
    end
end

// ===========================================================================
// flag next state
always @* begin
    nxt_flag = flag_ff;
    if (!edge_mode) begin
        nxt_flag = ~pin; // [R5] [R6]
    end else if (hit) begin
        nxt_flag = 1'b1; // [R7] [R13]
    end else if ((wr_zero && armed_ff) || accept) begin
        nxt_flag = 1'b0; // [R8] [R9]
    end
end

// read of a one arms the clear; the arm lapses once the flag is zero
always @* begin
    nxt_armed = armed_ff;
    if (rd_seen) begin
        nxt_armed = 1'b1; // [R8]
    end
    if (!nxt_flag || !edge_mode) begin
        nxt_armed = 1'b0; // [R12]
    end
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        flag_ff <= 1'b0; // [R4] [R11]
        armed_ff <= 1'b0;
    end else begin
        flag_ff <= nxt_flag;
        armed_ff <= nxt_armed;
    end
end

assign flag = flag_ff;
assign armed = armed_ff;
assign flag_rise = nxt_flag & ~flag_ff;

endmodule
`default_nettype wire

// *** rtl/eirq_status_top.v ***
// external request status block: eight request pins, flags, wishbone slave, interrupt
//
// Contract
// [R1] one 16-bit status register reports pin levels and request flags of eight pins.
// [R2] bits 15..8 are read-only live levels of pins 7..0, 1 when the pin is high.
// [R3] level bits have no reset value and show the pin as sampled when read.
// [R4] bits 7..3 are read/write request flags of pins 7..3, reset to 0.
// [R5] in level mode a flag reads 1 while its pin is low.
// [R6] in level mode a flag returns to 0 when its pin goes high, with no software help.
// [R7] in edge mode a flag sets on the selected edge and then holds.
// [R8] in edge mode software clears a flag by reading it as 1 then writing 0.
// [R9] in edge mode a flag also clears when its interrupt is accepted.
// [R10] two sense bits per pin: 00 low level, 01 falling, 10 rising, 11 both edges.
// [R11] bits 2..0 are flags of pins 2..0, same behaviour, reset to 0.
// [R12] writing 1, writing 0 without a prior read of 1, or writing in level mode is ignored.
// [R13] a new edge in the same cycle as a clear or an accept wins over the clear.
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "eirq_regs.vh"

module eirq_status_top (
    input wire clk,
    input wire rst_n,
    input wire wb_cyc,
    input wire wb_stb,
    input wire wb_we,
    input wire [7:0] wb_adr,
    input wire [3:0] wb_sel,
    input wire [31:0] wb_dat_wr,
    output wire [31:0] wb_dat_rd,
    output wire wb_ack,
    input wire [7:0] ext_request_pin,
    input wire [7:0] irq_accept,
    output wire [7:0] request_flag,
    output wire irq
);

// ===========================================================================
// register select decode
localparam SEL_STATUS = 5'b00001;
localparam SEL_SENSE = 5'b00010;
localparam SEL_EVT = 5'b00100;
localparam SEL_MASK = 5'b01000;
localparam SEL_ARMED = 5'b10000;
localparam SEL_NONE = 5'b00000;

function [4:0] reg_sel;
    input [7:0] adr;
    begin
        case (adr)
            `EIRQ_ADR_STATUS: reg_sel = SEL_STATUS;
            `EIRQ_ADR_SENSE: reg_sel = SEL_SENSE;
            `EIRQ_ADR_EVT: reg_sel = SEL_EVT;
            `EIRQ_ADR_MASK: reg_sel = SEL_MASK;
            `EIRQ_ADR_ARMED: reg_sel = SEL_ARMED;
            default: reg_sel = SEL_NONE;
        endcase
    end
endfunction

// ===========================================================================
// bus handshake state
reg ack_ff;
reg [31:0] rd_data_ff;
reg [31:0] nxt_rd_data;
wire req;
wire acc;
wire acc_wr;
wire acc_rd;
wire [4:0] sel_now;

// ===========================================================================
// configuration and interrupt registers
reg [15:0] ext_request_sense_config_reg_ff;
reg [15:0] nxt_sense;
reg [7:0] evt_ff;
reg [7:0] nxt_evt;
reg [7:0] mask_ff;
reg [7:0] nxt_mask;
reg irq_ff;

// ===========================================================================
// per-pin cell wiring
wire [7:0] flag_w;
wire [7:0] armed_w;
wire [7:0] rise_w;
wire [7:0] rd_seen_w;
wire [7:0] wr_zero_w;
wire [15:0] ext_request_status_reg;

// ===========================================================================
// request decode: a request is taken one cycle before ack, committed on ack
assign req = wb_cyc & wb_stb;
assign acc = req & ack_ff;
assign acc_wr = acc & wb_we;
assign acc_rd = acc & ~wb_we;
assign sel_now = reg_sel(wb_adr);

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        ack_ff <= 1'b0;
    end else begin
        ack_ff <= req & ~ack_ff;
    end
end

// ===========================================================================
// status word: live pin levels above, request flags below
assign ext_request_status_reg = {ext_request_pin, flag_w}; // [R1] [R2] [R3]

// ===========================================================================
// read data is captured as ack rises and holds through the ack cycle
always @* begin
    nxt_rd_data = rd_data_ff;
    if (req && !ack_ff) begin
        nxt_rd_data = `EIRQ_RST_DATA;
        if (!wb_we) begin
            case (sel_now)
                SEL_STATUS: nxt_rd_data = {16'h0000, ext_request_status_reg}; // [R1]
                SEL_SENSE: nxt_rd_data = {16'h0000, ext_request_sense_config_reg_ff};
                SEL_EVT: nxt_rd_data = {24'h00_0000, evt_ff};
                SEL_MASK: nxt_rd_data = {24'h00_0000, mask_ff};
                SEL_ARMED: nxt_rd_data = {24'h00_0000, armed_w};
                default: nxt_rd_data = `EIRQ_RST_DATA;
            endcase
        end
    end
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rd_data_ff <= `EIRQ_RST_DATA;
    end else begin
        rd_data_ff <= nxt_rd_data;
    end
end

// ===========================================================================
// sense configuration, byte lanes 0 and 1
always @* begin
    nxt_sense = ext_request_sense_config_reg_ff;
    if (acc_wr && sel_now == SEL_SENSE) begin
        if (wb_sel[0]) begin
            nxt_sense[7:0] = wb_dat_wr[7:0]; // [R10]
        end
        if (wb_sel[1]) begin
            nxt_sense[15:8] = wb_dat_wr[15:8]; // [R10]
        end
    end
end

// ===========================================================================
// interrupt mask, byte lane 0
always @* begin
    nxt_mask = mask_ff;
    if (acc_wr && sel_now == SEL_MASK && wb_sel[0]) begin
        nxt_mask = wb_dat_wr[7:0];
    end
end

// ===========================================================================
// event status: set on every flag rise, write one to clear, set wins
always @* begin
    nxt_evt = evt_ff;
    if (acc_wr && sel_now == SEL_EVT && wb_sel[0]) begin
        nxt_evt = evt_ff & ~wb_dat_wr[7:0];
    end
    nxt_evt = nxt_evt | rise_w;
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        ext_request_sense_config_reg_ff <= `EIRQ_RST_SENSE;
        mask_ff <= `EIRQ_RST_MASK;
        evt_ff <= `EIRQ_RST_EVT;
        irq_ff <= 1'b0;
    end else begin
        ext_request_sense_config_reg_ff <= nxt_sense;
        mask_ff <= nxt_mask;
        evt_ff <= nxt_evt;
        irq_ff <= |(evt_ff & mask_ff);
    end
end

// ===========================================================================
// per-pin flags; level bits are never written
genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
        // a read that returned this flag as one arms its clear
        assign rd_seen_w[gi] = acc_rd & (sel_now == SEL_STATUS) & rd_data_ff[gi]; // [R8]
        // only a zero in an enabled low byte lane clears; ones are ignored
        assign wr_zero_w[gi] = acc_wr & (sel_now == SEL_STATUS) & wb_sel[0]
            & ~wb_dat_wr[gi]; // [R8] [R12]
        eirq_flag_cell u_cell (
            .clk(clk),
            .rst_n(rst_n),
            .sense(ext_request_sense_config_reg_ff[2*gi+1:2*gi]),
            .pin(ext_request_pin[gi]),
            .rd_seen(rd_seen_w[gi]),
            .wr_zero(wr_zero_w[gi]),
            .accept(irq_accept[gi]),
            .flag(flag_w[gi]),
            .armed(armed_w[gi]),
            .flag_rise(rise_w[gi])
        ); // [R4] [R11] [R9] [R13]
    end
endgenerate

// ===========================================================================
// outputs
assign wb_ack = ack_ff;
assign wb_dat_rd = rd_data_ff;
assign request_flag = flag_w;
assign irq = irq_ff;

endmodule
`default_nettype wire

// *** tb/eirq_status_chk.sv ***
// assertion checker for the external request status block
`timescale 1ns/1ps
`default_nettype none
module eirq_status_chk (
    input wire clk,
    input wire rst_n,
    input wire wb_cyc,
    input wire wb_stb,
    input wire wb_we,
    input wire [7:0] wb_adr,
    input wire [3:0] wb_sel,
    input wire [31:0] wb_dat_wr,
    input wire [31:0] wb_dat_rd,
    input wire wb_ack,
    input wire [7:0] ext_request_pin,
    input wire [7:0] irq_accept,
    input wire [7:0] request_flag,
    input wire irq
);
    // ==========================================================
    // shadow of sense and mask, previous pin sample
    logic [15:0] sense_ff;
    logic [7:0] mask_ff;
    logic [7:0] pin_q_ff;
    logic [7:0] lvl;
    logic [7:0] set_v;
    logic [7:0] acc_clr;
    logic wr_ok;
    logic st_wr;
    assign wr_ok = wb_ack & wb_cyc & wb_stb & wb_we;
    assign st_wr = wr_ok & (wb_adr == 8'h00);
    assign acc_clr = irq_accept & ~lvl & ~set_v;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sense_ff <= 16'h0000;
            mask_ff <= 8'h00;
        end else begin
            pin_q_ff <= ext_request_pin;
            if (wr_ok && wb_adr == 8'h04 && wb_sel[0]) sense_ff[7:0] <= wb_dat_wr[7:0];
            if (wr_ok && wb_adr == 8'h04 && wb_sel[1]) sense_ff[15:8] <= wb_dat_wr[15:8];
            if (wr_ok && wb_adr == 8'h0c && wb_sel[0]) mask_ff <= wb_dat_wr[7:0];
        end
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lvl[i] = sense_ff[2*i+:2] == 2'h0;
            set_v[i] = (sense_ff[2*i] & pin_q_ff[i] & ~ext_request_pin[i])
                | (sense_ff[2*i+1] & ~pin_q_ff[i] & ext_request_pin[i]);
        end
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ack_one_pulse: assert property (wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");
    a_ack_after_req: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("request not answered in one cycle");
    a_status_read: assert property (wb_ack && !wb_we && wb_adr == 8'h00
        |-> wb_dat_rd == {16'h0000, $past(ext_request_pin), $past(request_flag)})
        else $error("status read value wrong");
    a_level_follow: assert property ($past(rst_n)
        |-> ((request_flag ^ ~$past(ext_request_pin)) & $past(lvl)) == 8'h00)
        else $error("level flag not following pin");
    a_edge_set: assert property ($past(rst_n) |-> ($past(set_v) & ~request_flag) == 8'h00)
        else $error("selected edge did not set flag");
    a_edge_hold: assert property ($past(rst_n) && !$past(st_wr)
        |-> ($past(request_flag) & ~request_flag & ~$past(lvl) & ~$past(irq_accept)) == 8'h00)
        else $error("edge flag dropped without cause");
    a_accept_clear: assert property ($past(rst_n) |-> ($past(acc_clr) & request_flag) == 8'h00)
        else $error("accept did not clear flag");
    a_irq_masked: assert property (irq |-> $past(mask_ff) != 8'h00)
        else $error("interrupt with all sources masked");
endmodule
bind eirq_status_top eirq_status_chk eirq_status_chk_i (.clk(clk), .rst_n(rst_n),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack),
    .ext_request_pin(ext_request_pin), .irq_accept(irq_accept),
    .request_flag(request_flag), .irq(irq));
`default_nettype wire

// *** tb/eirq_pin_dev.sv ***
// external device model driving the request pins
`timescale 1ns/1ps
`default_nettype none
module eirq_pin_dev (
    input wire clk,
    input wire logic [7:0] want,
    output var logic [7:0] pin
);
    // pins move only just after a clock edge
    initial pin = 8'hff;
    always @(posedge clk) begin
        pin <= want;
    end
endmodule
`default_nettype wire

// *** tb/test_ext_irq_status_flags.sv ***
// self-checking bench for the external request status block
`timescale 1ns/1ps
`default_nettype none
module test_ext_irq_status_flags;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dw = 32'h0000_0000;
    logic [7:0] want = 8'hff;
    logic [7:0] acc = 8'h00;
    logic [31:0] q;
    wire [31:0] rd;
    wire ack;
    wire [7:0] pin;
    wire [7:0] flag;
    wire irq;
    int fail_count = 0;
    int check_count = 0;
    // sense code, first pin level, second pin level, expected flags
    logic [7:0] rows [5][4] = '{'{8'h00, 8'hff, 8'h0f, 8'hf0}, '{8'h01, 8'hff, 8'h0f, 8'hf0},
        '{8'h02, 8'h00, 8'h3c, 8'h3c}, '{8'h03, 8'h0f, 8'hf0, 8'hff},
        '{8'h01, 8'h00, 8'hff, 8'h00}};
    always #25 clk = ~clk;
    eirq_pin_dev eirq_pin_dev_i (.clk(clk), .want(want), .pin(pin));
    eirq_status_top eirq_status_top_i (.clk(clk), .rst_n(rst_n), .wb_cyc(cyc), .wb_stb(stb),
        .wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_dat_wr(dw), .wb_dat_rd(rd), .wb_ack(ack),
        .ext_request_pin(pin), .irq_accept(acc), .request_flag(flag), .irq(irq));
    // ==========================================================
    // helpers
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        sel <= 4'h3;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            fail_count++;
            summarize();
        end
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse();
        acc <= 8'hff;
        @(posedge clk);
        acc <= 8'h00;
        @(posedge clk);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        chk(flag, 8'h00);
        chk(irq, 1'b0);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int r = 0; r < 5; r++) begin
            want <= rows[r][1];
            wb(1'b1, 8'h04, {16'h0000, {8{rows[r][0][1:0]}}});
            repeat (3) @(posedge clk);
            pulse();
            want <= rows[r][2];
            repeat (3) @(posedge clk);
            wb(1'b0, 8'h00, 32'h0000_0000);
            chk(q, {16'h0000, rows[r][2], rows[r][3]});
            pulse();
            chk(flag, rows[r][0] == 8'h00 ? {24'h00_0000, ~rows[r][2]} : 32'h0000_0000);
            $display("row %0d done", r);
        end
        want <= 8'h00;
        repeat (3) @(posedge clk);
        wb(1'b1, 8'h00, 32'h0000_ff00);
        chk(flag, 8'hff);
        wb(1'b0, 8'h00, 32'h0000_0000);
        chk(q, 32'h0000_00ff);
        wb(1'b1, 8'h00, 32'h0000_fff0);
        chk(flag, 8'hf0);
        wb(1'b0, 8'h10, 32'h0000_0000);
        chk(q, 32'h0000_00f0);
        $display("software clear done");
        want <= 8'hff;
        repeat (3) @(posedge clk);
        wb(1'b1, 8'h08, 32'h0000_00ff);
        want <= 8'h00;
        @(posedge clk);
        acc <= 8'hff;
        @(posedge clk);
        acc <= 8'h00;
        @(posedge clk);
        chk(flag, 8'hff);
        chk(irq, 1'b0);
        wb(1'b1, 8'h0c, 32'h0000_0001);
        @(posedge clk);
        chk(irq, 1'b1);
        wb(1'b1, 8'h08, 32'h0000_0001);
        @(posedge clk);
        chk(irq, 1'b0);
        wb(1'b0, 8'h08, 32'h0000_0000);
        chk(q, 32'h0000_000e);
        $display("set priority and interrupt done");
        wb(1'b0, 8'h20, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        wb(1'b0, 8'h04, 32'h0000_0000);
        chk(q, 32'h0000_5555);
        rst_n <= 1'b0;
        @(posedge clk);
        chk(flag, 8'h00);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk(flag, 8'hff);
        wb(1'b0, 8'h00, 32'h0000_0000);
        chk(q, 32'h0000_00ff);
        wb(1'b0, 8'h04, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        $display("map and second reset done");
        summarize();
    end
endmodule
`default_nettype wire
